// file: esu_defs.vh
// Overview of operation
// - Nonfatal alarm flashes error lamp, keeps running
// - Nonfatal alarm number goes to status code
// - Fatal alarm number goes to status code
// - With clock cassette, log code and time
// - Nonfatal alarm or failure point clear needs alarm 00 first, then console
// - Fatal alarm stops execution, outputs off, lamp steady
// - Fatal clear only in program mode
// - Message instruction shows up to 16 characters
// - Failure point detect raises nonfatal, sends message
// - Nonfatal error keeps power and run lamps lit
// - Cassette transfer failure: code 9D, cause flags
// - Board fault: code 9C, BCD detail byte
// - Setup fault: code 9B, exactly one phase flag
// - Watchdog over 100 ms: code F8, bit 9
// - Weak battery: code F7, bit 8, if enabled
// - Port error stops its lamp; reset bit reinitialises
// - Output inhibit forces outputs off, lights lamp
// - Fatal error: power, error lamps on, run off
`ifndef ESU_DEFS_VH
`define ESU_DEFS_VH

// Register byte offsets
`define ESU_A_CTRL   5'h00
`define ESU_A_STAT   5'h04
`define ESU_A_XFER   5'h08
`define ESU_A_BOARD  5'h0C
`define ESU_A_SETUP  5'h10
`define ESU_A_CLR    5'h14

// Control word fields
`define ESU_CTRL_BATT_EN 0
`define ESU_CTRL_PRST0   8
`define ESU_CTRL_PRST1   9
`define ESU_CTRL_INH     15
`define ESU_BATT_EN_RST  1'b1

// Status word fields
`define ESU_ST_BATT  8
`define ESU_ST_WD    9
`define ESU_ST_NF    16
`define ESU_ST_FT    17
`define ESU_CLR_BIT  0

// Detail field positions
`define ESU_XFER_LSB  12
`define ESU_BOARD_LSB 8

// Error codes
`define ESU_CODE_NONE 8'h00
`define ESU_CODE_XFER 8'h9D
`define ESU_CODE_BRD  8'h9C
`define ESU_CODE_SET  8'h9B
`define ESU_CODE_WD   8'hF8
`define ESU_CODE_BAT  8'hF7

// Setup fault phases
`define ESU_PH_PWR   2'h0
`define ESU_PH_RUN   2'h1
`define ESU_PH_OPER  2'h2

// Message limit
`define ESU_MSG_MAX  5'h10

// Timing
`define ESU_CLK_HZ     100000000
`define ESU_WD_MS      100
`define ESU_BLINK_MS   250
`define ESU_WD_CYC     (`ESU_WD_MS * (`ESU_CLK_HZ / 1000))
`define ESU_BLINK_CYC  (`ESU_BLINK_MS * (`ESU_CLK_HZ / 1000))

`endif

// file: esu_blink.v
`timescale 1ns/1ps
`default_nettype none
module esu_blink #(
  parameter [31:0] HALF = 32'h0000_0010
) (
  // Clock and control
  input  wire core_clk_in,
  input  wire rstn_in,
  input  wire ce_in,
  // Square wave
  output reg  blink_out
);
  reg [31:0] cnt; // Cycles into current half period

  // Toggle every HALF cycles
  always @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      cnt       <= 32'h0000_0000;
      blink_out <= 1'b0;
    end
    else if (ce_in)
    begin
      if (cnt >= HALF - 32'h0000_0001)
      begin
        cnt       <= 32'h0000_0000;
        blink_out <= ~blink_out;
      end
      else
        cnt <= cnt + 32'h0000_0001;
    end
  end
endmodule
`default_nettype wire

// file: esu_port_ctl.v
`timescale 1ns/1ps
`default_nettype none
module esu_port_ctl (
  // Clock and control
  input  wire core_clk_in,
  input  wire rstn_in,
  input  wire ce_in,
  // Port status
  input  wire blink_in,
  input  wire active_in,
  input  wire err_in,
  input  wire port_rst_in,
  // Indicator and state
  output reg  lamp_out,
  output reg  err_out
);
  // Error latch; a new error beats a reset in the same cycle
  always @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      err_out  <= 1'b0;
      lamp_out <= 1'b0;
    end
    else if (ce_in)
    begin
      if (err_in)
        err_out <= 1'b1;
      else if (port_rst_in)
        err_out <= 1'b0;
      // Lamp flashes with traffic, frozen dark on error
      lamp_out <= active_in & ~err_out & ~err_in & blink_in;
    end
  end
endmodule
`default_nettype wire

// file: esu_top.v
// The address map and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "esu_defs.vh"
module esu_top #(
  parameter [31:0] WD_CYC    = `ESU_WD_CYC,
  parameter [31:0] BLINK_CYC = `ESU_BLINK_CYC
) (
  // Clock, reset, enable
  input  wire        core_clk_in,
  input  wire        rstn_in,
  input  wire        ce_in,
  // Avalon-MM slave
  input  wire [4:0]  avs_address_in,
  input  wire        avs_read_in,
  input  wire        avs_write_in,
  input  wire [31:0] avs_writedata_in,
  output reg  [31:0] avs_readdata_out,
  output reg         avs_waitrequest_out,
  // Instruction events from the executing program
  input  wire        nonfatal_alarm_instr_in,
  input  wire        fatal_alarm_instr_in,
  input  wire        failure_point_detect_instr_in,
  input  wire [7:0]  alarm_num_in,
  input  wire        console_message_instr_in,
  input  wire [4:0]  msg_len_in,
  // System conditions
  input  wire        xfer_err_in,
  input  wire [3:0]  xfer_cause_in,
  input  wire        board_fault_in,
  input  wire [7:0]  board_detail_in,
  input  wire        setup_fault_in,
  input  wire [1:0]  setup_phase_in,
  input  wire        cycle_start_in,
  input  wire        battery_weak_error_in,
  input  wire [1:0]  port_active_in,
  input  wire [1:0]  port_err_in,
  input  wire        program_mode_in,
  // Error log cassette
  input  wire        rtc_present_in,
  input  wire [31:0] rtc_time_in,
  output reg         log_valid_out,
  output reg  [7:0]  log_code_out,
  output reg  [31:0] log_time_out,
  // Console message
  output reg         msg_show_out,
  output reg  [4:0]  msg_len_out,
  output reg         fpd_msg_out,
  // Execution and outputs
  output reg         exec_run_out,
  output reg         outputs_on_out,
  // Lamps
  output reg         power_lamp_out,
  output reg         run_lamp_out,
  output reg         error_lamp_out,
  output reg         output_block_lamp_out,
  output wire        peripheral_port_lamp_out,
  output wire        serial_port_lamp_out
);
  // Bus handshake
  wire        req     = avs_read_in | avs_write_in; // Pending request
  wire        wr_fire = avs_write_in & ~avs_waitrequest_out; // Write taken
  // Software state
  reg         batt_en;      // Battery detection enable
  reg         inhibit;      // Output inhibit bit
  // Error state
  reg  [7:0]  code;         // Status code field
  reg         nf_act;       // Nonfatal error standing
  reg         ft_act;       // Fatal error standing
  reg         fal_pend;     // User alarm needs number 00 first
  reg         fal_zero;     // Number 00 seen since user alarm
  reg         batt_flag;    // Battery status bit
  reg         wd_flag;      // Watchdog status bit
  reg  [3:0]  xfer_flags;   // Transfer cause flags
  reg  [7:0]  board_det;    // Board fault detail
  reg  [2:0]  setup_flags;  // Setup fault phase flags
  reg  [31:0] wd_cnt;       // Cycle watchdog timer
  reg         wd_seen;      // Watchdog already fired this cycle
  wire        blink;        // Shared flash clock
  wire [1:0]  port_err;     // Latched port errors
  // Decoded requests
  wire        clr_req  = wr_fire & (avs_address_in == `ESU_A_CLR)
                         & avs_writedata_in[`ESU_CLR_BIT];
  wire        ctrl_wr  = wr_fire & (avs_address_in == `ESU_A_CTRL);
  wire [1:0]  port_rst = {2{ctrl_wr}} &
                         {avs_writedata_in[`ESU_CTRL_PRST1],
                          avs_writedata_in[`ESU_CTRL_PRST0]};
  // Alarm number zero is the release marker
  wire        num_zero = (alarm_num_in == `ESU_CODE_NONE);
  wire        fal_ev   = nonfatal_alarm_instr_in & ~num_zero;
  wire        fpd_ev   = failure_point_detect_instr_in & ~num_zero;
  wire        fatal_alarm_instr_ev  = fatal_alarm_instr_in & ~num_zero;
  wire        wd_ev    = (wd_cnt >= WD_CYC) & ~wd_seen;
  wire        bat_ev   = battery_weak_error_in & batt_en;
  // Any nonfatal cause this cycle
  wire        nf_ev    = fal_ev | fpd_ev | xfer_err_in | board_fault_in
                         | setup_fault_in | wd_ev | bat_ev;
  // Clear permissions
  wire        nf_clr   = clr_req & (~fal_pend | fal_zero);
  wire        ft_clr   = clr_req & program_mode_in;
  reg  [7:0]  next_code;    // Code chosen this cycle
  reg  [31:0] rd_mux;       // Read data selection

  // Flash source for error and port lamps
  esu_blink #(
    .HALF (BLINK_CYC)
  ) u_blink (
    .core_clk_in (core_clk_in),
    .rstn_in     (rstn_in),
    .ce_in       (ce_in),
    .blink_out   (blink)
  );

  // Peripheral port indicator
  esu_port_ctl u_port0 (
    .core_clk_in (core_clk_in),
    .rstn_in     (rstn_in),
    .ce_in       (ce_in),
    .blink_in    (blink),
    .active_in   (port_active_in[0]),
    .err_in      (port_err_in[0]),
    .port_rst_in (port_rst[0]),
    .lamp_out    (peripheral_port_lamp_out),
    .err_out     (port_err[0])
  );

  // Serial port indicator
  esu_port_ctl u_port1 (
    .core_clk_in (core_clk_in),
    .rstn_in     (rstn_in),
    .ce_in       (ce_in),
    .blink_in    (blink),
    .active_in   (port_active_in[1]),
    .err_in      (port_err_in[1]),
    .port_rst_in (port_rst[1]),
    .lamp_out    (serial_port_lamp_out),
    .err_out     (port_err[1])
  );

  // Code priority: fatal first, then user alarms, then system causes
  always @*
  begin
    next_code = code;
    if (fatal_alarm_instr_ev)
      next_code = alarm_num_in;
    else if (ft_act & ~ft_clr)
      next_code = code;
    else if (fal_ev | fpd_ev)
      next_code = alarm_num_in;
    else if (xfer_err_in)
      next_code = `ESU_CODE_XFER;
    else if (board_fault_in)
      next_code = `ESU_CODE_BRD;
    else if (setup_fault_in)
      next_code = `ESU_CODE_SET;
    else if (wd_ev)
      next_code = `ESU_CODE_WD;
    else if (bat_ev)
      next_code = `ESU_CODE_BAT;
    else if (nf_clr)
      next_code = `ESU_CODE_NONE;
    else if (ft_clr & ~nf_act)
      next_code = `ESU_CODE_NONE;
  end

  // Read data multiplexer; unmapped words read zero
  always @*
  begin
    rd_mux = 32'h0000_0000;
    case (avs_address_in)
      `ESU_A_CTRL:
      begin
        rd_mux[`ESU_CTRL_BATT_EN] = batt_en;
        rd_mux[`ESU_CTRL_INH]     = inhibit;
      end
      `ESU_A_STAT:
      begin
        rd_mux[7:0]          = code;
        rd_mux[`ESU_ST_BATT] = batt_flag;
        rd_mux[`ESU_ST_WD]   = wd_flag;
        rd_mux[`ESU_ST_NF]   = nf_act;
        rd_mux[`ESU_ST_FT]   = ft_act;
      end
      `ESU_A_XFER:
        rd_mux[`ESU_XFER_LSB+3:`ESU_XFER_LSB] = xfer_flags;
      `ESU_A_BOARD:
        rd_mux[`ESU_BOARD_LSB+7:`ESU_BOARD_LSB] = board_det;
      `ESU_A_SETUP:
        rd_mux[2:0] = setup_flags;
      default:
        rd_mux = 32'h0000_0000;
    endcase
  end

  // Bus slave: one wait cycle, then the answer for one cycle
  always @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out    <= 32'h0000_0000;
    end
    else if (ce_in)
    begin
      if (req & avs_waitrequest_out)
      begin
        avs_waitrequest_out <= 1'b0;
        avs_readdata_out    <= rd_mux;
      end
      else
        avs_waitrequest_out <= 1'b1;
    end
  end

  // Software control bits
  always @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      batt_en <= `ESU_BATT_EN_RST;
      inhibit <= 1'b0;
    end
    else if (ce_in & ctrl_wr)
    begin
      batt_en <= avs_writedata_in[`ESU_CTRL_BATT_EN];
      inhibit <= avs_writedata_in[`ESU_CTRL_INH];
    end
  end

  // Cycle watchdog; restarted by every scan start
  always @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      wd_cnt  <= 32'h0000_0000;
      wd_seen <= 1'b0;
    end
    else if (ce_in)
    begin
      if (cycle_start_in | ~exec_run_out)
      begin
        wd_cnt  <= 32'h0000_0000;
        wd_seen <= 1'b0;
      end
      else
      begin
        // Saturate so a stuck scan cannot wrap and rearm
        if (wd_cnt < WD_CYC)
          wd_cnt <= wd_cnt + 32'h0000_0001;
        if (wd_ev)
          wd_seen <= 1'b1;
      end
    end
  end

  // Error state; every new event beats a clear in the same cycle
  always @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      code        <= `ESU_CODE_NONE;
      nf_act      <= 1'b0;
      ft_act      <= 1'b0;
      fal_pend    <= 1'b0;
      fal_zero    <= 1'b0;
      batt_flag   <= 1'b0;
      wd_flag     <= 1'b0;
      xfer_flags  <= 4'h0;
      board_det   <= 8'h00;
      setup_flags <= 3'h0;
    end
    else if (ce_in)
    begin
      code <= next_code;
      // Fatal standing flag
      if (fatal_alarm_instr_ev)
        ft_act <= 1'b1;
      else if (ft_clr)
        ft_act <= 1'b0;
      // Nonfatal standing flag
      if (nf_ev)
        nf_act <= 1'b1;
      else if (nf_clr)
        nf_act <= 1'b0;
      // User alarm release tracking
      if (fal_ev | fpd_ev)
      begin
        fal_pend <= 1'b1;
        fal_zero <= 1'b0;
      end
      else if (nf_clr)
      begin
        fal_pend <= 1'b0;
        fal_zero <= 1'b0;
      end
      else if (nonfatal_alarm_instr_in & num_zero)
        fal_zero <= 1'b1;
      // Transfer cause flags
      if (xfer_err_in)
        xfer_flags <= xfer_flags | xfer_cause_in;
      else if (nf_clr)
        xfer_flags <= 4'h0;
      // Board detail byte
      if (board_fault_in)
        board_det <= board_detail_in;
      else if (nf_clr)
        board_det <= 8'h00;
      // One flag per detection phase
      if (setup_fault_in)
      begin
        case (setup_phase_in)
          `ESU_PH_PWR:  setup_flags <= 3'b001;
          `ESU_PH_RUN:  setup_flags <= 3'b010;
          `ESU_PH_OPER: setup_flags <= 3'b100;
          default:      setup_flags <= setup_flags;
        endcase
      end
      else if (nf_clr)
        setup_flags <= 3'h0;
      // Watchdog status bit
      if (wd_ev)
        wd_flag <= 1'b1;
      else if (nf_clr)
        wd_flag <= 1'b0;
      // Battery bit latches while enabled; cleared by a clear or by disabling
      if (bat_ev)
        batt_flag <= 1'b1;
      else if (nf_clr | ~batt_en)
        batt_flag <= 1'b0;
    end
  end

  // Error log record, only with a clock-equipped cassette
  always @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      log_valid_out <= 1'b0;
      log_code_out  <= `ESU_CODE_NONE;
      log_time_out  <= 32'h0000_0000;
    end
    else if (ce_in)
    begin
      log_valid_out <= rtc_present_in & (fatal_alarm_instr_ev | fal_ev | fpd_ev);
      if (fatal_alarm_instr_ev | fal_ev | fpd_ev)
      begin
        log_code_out <= alarm_num_in;
        log_time_out <= rtc_time_in;
      end
    end
  end

  // Console message and failure point message
  always @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      msg_show_out <= 1'b0;
      msg_len_out  <= 5'h00;
      fpd_msg_out  <= 1'b0;
    end
    else if (ce_in)
    begin
      msg_show_out <= console_message_instr_in;
      // Longer requests are cut to the console width
      if (msg_len_in > `ESU_MSG_MAX)
        msg_len_out <= `ESU_MSG_MAX;
      else
        msg_len_out <= msg_len_in;
      fpd_msg_out <= failure_point_detect_instr_in;
    end
  end

  // Execution, output gating and lamps
  always @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      exec_run_out          <= 1'b0;
      outputs_on_out        <= 1'b0;
      power_lamp_out        <= 1'b0;
      run_lamp_out          <= 1'b0;
      error_lamp_out        <= 1'b0;
      output_block_lamp_out <= 1'b0;
    end
    else if (ce_in)
    begin
      // A fatal event takes effect on the next edge
      exec_run_out   <= ~(ft_act | fatal_alarm_instr_ev) & ~program_mode_in;
      outputs_on_out <= ~(ft_act | fatal_alarm_instr_ev) & ~inhibit
                        & ~program_mode_in;
      output_block_lamp_out <= inhibit;
      power_lamp_out <= 1'b1;
      run_lamp_out   <= ~(ft_act | fatal_alarm_instr_ev) & ~program_mode_in;
      if (ft_act | fatal_alarm_instr_ev)
        error_lamp_out <= 1'b1;
      else if (nf_act)
        error_lamp_out <= blink;
      else
        error_lamp_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: esu_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
module esu_chk (
  // Clock and reset
  input wire logic       core_clk_in,
  input wire logic       rstn_in,
  input wire logic       ce_in,
  // Instruction events
  input wire logic       nonfatal_alarm_instr_in,
  input wire logic       fatal_alarm_instr_in,
  input wire logic       failure_point_detect_instr_in,
  input wire logic [7:0] alarm_num_in,
  input wire logic       console_message_instr_in,
  input wire logic [1:0] port_err_in,
  input wire logic       program_mode_in,
  input wire logic       rtc_present_in,
  // Observed results
  input wire logic       log_valid_out,
  input wire logic [7:0] log_code_out,
  input wire logic       msg_show_out,
  input wire logic [4:0] msg_len_out,
  input wire logic       fpd_msg_out,
  input wire logic       exec_run_out,
  input wire logic       outputs_on_out,
  input wire logic       power_lamp_out,
  input wire logic       run_lamp_out,
  input wire logic       error_lamp_out,
  input wire logic       output_block_lamp_out,
  input wire logic       peripheral_port_lamp_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);
  // Nonfatal alarm while running, nothing fatal alongside
  sequence s_nf;
    ce_in && nonfatal_alarm_instr_in && alarm_num_in != 8'h00 && !fatal_alarm_instr_in
      && exec_run_out && !program_mode_in;
  endsequence
  // Fatal alarm with a real number
  sequence s_ft;
    ce_in && fatal_alarm_instr_in && alarm_num_in != 8'h00;
  endsequence
  // Lamp must go on and off again; bench blink half period is 4
  sequence s_flash;
    ##[1:10] error_lamp_out ##[1:10] !error_lamp_out;
  endsequence
  AST_NF_FLASH: assert property (s_nf |-> s_flash)
    else $error("error lamp not flashing after nonfatal alarm");
  AST_NF_RUNS: assert property (s_nf |=> exec_run_out && run_lamp_out && power_lamp_out)
    else $error("nonfatal alarm stopped execution or lamps");
  AST_FT_STOP: assert property (s_ft |=> !exec_run_out && !outputs_on_out)
    else $error("fatal alarm left execution or outputs on");
  AST_FT_LAMPS: assert property (s_ft |=> power_lamp_out && !run_lamp_out)
    else $error("fatal alarm lamp pattern wrong");
  AST_FT_STEADY: assert property (s_ft |=> error_lamp_out [*8])
    else $error("error lamp not steady under fatal alarm");
  AST_LOG: assert property (ce_in && rtc_present_in && alarm_num_in != 8'h00
    && (nonfatal_alarm_instr_in || fatal_alarm_instr_in || failure_point_detect_instr_in)
    |=> log_valid_out && log_code_out == $past(alarm_num_in))
    else $error("alarm not logged with its number");
  AST_MSG: assert property (ce_in |=> msg_show_out == $past(console_message_instr_in)
    && msg_len_out <= 5'h10)
    else $error("message display wrong");
  AST_FPD: assert property (ce_in && failure_point_detect_instr_in && alarm_num_in != 8'h00
    |=> fpd_msg_out)
    else $error("no message pulse after failure point detect");
  AST_INHIBIT: assert property (output_block_lamp_out |-> !outputs_on_out)
    else $error("outputs on while inhibit lamp lit");
  AST_PORT: assert property (ce_in && port_err_in[0] |-> ##2 !peripheral_port_lamp_out [*3])
    else $error("port lamp still flashing after port error");
endmodule
bind esu_top esu_chk chk (.*);
`default_nettype wire

// file: esu_con_model.sv
`timescale 1ns/1ps
`default_nettype none
module esu_con_model (
  // Clock and slave answer
  input  wire logic        core_clk_in,
  input  wire logic        waitrequest_in,
  input  wire logic [31:0] readdata_in,
  // Console request
  output var logic  [4:0]  address_out,
  output var logic         read_out,
  output var logic         write_out,
  output var logic  [31:0] writedata_out
);
  // Idle bus from time zero
  initial
  begin
    {address_out, read_out, write_out, writedata_out} = '0;
  end
  // One access, held until waitrequest is sampled low at an edge
  task automatic xfer(input logic wr, input logic [4:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge core_clk_in);
    address_out <= a;
    writedata_out <= wd;
    read_out <= !wr;
    write_out <= wr;
    @(posedge core_clk_in);
    while (waitrequest_in !== 1'b0)
      @(posedge core_clk_in);
    rd = readdata_in;
    read_out <= 1'b0;
    write_out <= 1'b0;
    // Released lines show garbage, not the last value
    address_out <= ~a;
    writedata_out <= ~wd;
  endtask
endmodule
`default_nettype wire

// file: testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "esu_defs.vh"
module testbench;
  // Design inputs and outputs, named as the ports
  logic core_clk_in, rstn_in, ce_in, nonfatal_alarm_instr_in, fatal_alarm_instr_in;
  logic failure_point_detect_instr_in, console_message_instr_in, xfer_err_in;
  logic board_fault_in, setup_fault_in, cycle_start_in, battery_weak_error_in;
  logic program_mode_in, rtc_present_in, log_valid_out, msg_show_out, fpd_msg_out;
  logic exec_run_out, outputs_on_out, power_lamp_out, run_lamp_out, error_lamp_out;
  logic output_block_lamp_out, peripheral_port_lamp_out, serial_port_lamp_out;
  logic avs_waitrequest_out;
  logic [7:0]  alarm_num_in, board_detail_in, log_code_out;
  logic [4:0]  msg_len_in, msg_len_out;
  logic [3:0]  xfer_cause_in;
  logic [1:0]  setup_phase_in, port_active_in, port_err_in;
  logic [31:0] rtc_time_in, log_time_out, avs_readdata_out, rd;
  wire  [4:0]  avs_address_in;
  wire  [31:0] avs_writedata_in;
  wire         avs_read_in, avs_write_in;
  // Bench state
  integer mismatches, check_count, cycles, seed, i, p;
  logic wd_feed, seen;
  logic [7:0] n1, n2;

  esu_top #(.WD_CYC(32'h0000_0032), .BLINK_CYC(32'h0000_0004)) uut (.*);
  esu_con_model con (.core_clk_in(core_clk_in), .waitrequest_in(avs_waitrequest_out),
    .readdata_in(avs_readdata_out), .address_out(avs_address_in), .read_out(avs_read_in),
    .write_out(avs_write_in), .writedata_out(avs_writedata_in));

  // Clock
  initial
  begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end
  // Scan starts every 20 cycles keep the watchdog quiet; hang guard
  always @(posedge core_clk_in)
  begin
    cycles <= cycles + 1;
    cycle_start_in <= wd_feed && (cycles % 20 == 0);
    if (cycles == 30000)
    begin
      mismatches = mismatches + 1;
      give_verdict;
    end
  end

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    check_count = check_count + 1;
    if (got !== exp)
    begin
      mismatches = mismatches + 1;
      $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    con.xfer(1'b1, a, d, rd);
  endtask
  task automatic rdchk(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
    con.xfer(1'b0, a, 32'h0, rd);
    chk(e, rd & m);
  endtask
  // Expected status word: code, nonfatal and fatal flags
  function automatic logic [31:0] st(input logic [7:0] c, input logic nf, input logic ft);
    st = {14'h0, ft, nf, 8'h00, c};
  endfunction
  function automatic logic [7:0] bcd(input integer v);
    bcd = {4'(v / 10), 4'(v % 10)};
  endfunction
  // One event pulse of kind k; outputs settled on return
  task automatic ev(input integer k, input logic [7:0] n);
    @(posedge core_clk_in);
    alarm_num_in <= n;
    rtc_time_in <= $random(seed);
    xfer_cause_in <= n[3:0];
    board_detail_in <= n;
    setup_phase_in <= n[1:0];
    {nonfatal_alarm_instr_in, fatal_alarm_instr_in, failure_point_detect_instr_in,
     xfer_err_in, board_fault_in, setup_fault_in} <= 6'h20 >> k;
    @(posedge core_clk_in);
    {nonfatal_alarm_instr_in, fatal_alarm_instr_in, failure_point_detect_instr_in,
     xfer_err_in, board_fault_in, setup_fault_in} <= 6'h00;
    #1;
  endtask

  initial
  begin
    {rstn_in, nonfatal_alarm_instr_in, fatal_alarm_instr_in, failure_point_detect_instr_in,
     console_message_instr_in, xfer_err_in, board_fault_in, setup_fault_in, cycle_start_in,
     battery_weak_error_in, program_mode_in, alarm_num_in, board_detail_in, msg_len_in,
     xfer_cause_in, setup_phase_in, port_err_in, rtc_time_in} = '0;
    {mismatches, check_count, cycles} = '0;
    seed = 32'hbb8a;
    {ce_in, rtc_present_in, wd_feed} = 3'h7;
    port_active_in = 2'h3;
    repeat (8) @(posedge core_clk_in);
    rstn_in <= 1'b1;
    rdchk(`ESU_A_CTRL, 32'hFFFF_FFFF, 32'h0000_0001);
    rdchk(5'h18, 32'hFFFF_FFFF, 32'h0000_0000);
    // User alarms, nonfatal and failure point detect, with number corners
    for (i = 0; i < 4; i++)
    begin
      n1 = (i == 0) ? 8'h01 : (i == 1) ? 8'h99 : bcd(1 + {$random(seed)} % 99);
      ev((i % 2) * 2, n1);
      chk({log_valid_out, log_code_out}, {1'b1, n1});
      chk(log_time_out, rtc_time_in);
      chk(exec_run_out, 1'b1);
      if (i % 2)
        chk(fpd_msg_out, 1'b1);
      repeat (25) @(posedge core_clk_in);
      rdchk(`ESU_A_STAT, 32'h0003_00FF, st(n1, 1'b1, 1'b0));
      wr(`ESU_A_CLR, 32'h1);
      rdchk(`ESU_A_STAT, 32'h0003_00FF, st(n1, 1'b1, 1'b0));
      ev(0, 8'h00);
      wr(`ESU_A_CLR, 32'h1);
      rdchk(`ESU_A_STAT, 32'h0003_00FF, st(8'h00, 1'b0, 1'b0));
    end
    // System conditions: transfer, board, setup phases
    for (i = 0; i < 5; i++)
    begin
      n1 = (i == 0) ? 8'(1 + {$random(seed)} % 15) : (i == 1) ? bcd(1 + {$random(seed)} % 4)
           : 8'(i - 2);
      ev((i < 2) ? 3 + i : 5, n1);
      rdchk(`ESU_A_STAT, 32'h0000_00FF, (i == 0) ? 32'h9D : (i == 1) ? 32'h9C : 32'h9B);
      if (i == 0)
        rdchk(`ESU_A_XFER, 32'hFFFF_FFFF, {16'h0, n1[3:0], 12'h0});
      else if (i == 1)
        rdchk(`ESU_A_BOARD, 32'hFFFF_FFFF, {16'h0, n1, 8'h0});
      else
        rdchk(`ESU_A_SETUP, 32'hFFFF_FFFF, 32'h1 << n1);
      wr(`ESU_A_CLR, 32'h1);
    end
    // Watchdog starved, then fed again
    wd_feed = 1'b0;
    repeat (60) @(posedge core_clk_in);
    rdchk(`ESU_A_STAT, 32'h0000_02FF, 32'h0000_02F8);
    wd_feed = 1'b1;
    wr(`ESU_A_CLR, 32'h1);
    // Weak battery, then detection disabled
    battery_weak_error_in <= 1'b1;
    repeat (3) @(posedge core_clk_in);
    rdchk(`ESU_A_STAT, 32'h0000_01FF, 32'h0000_01F7);
    wr(`ESU_A_CTRL, 32'h0);
    rdchk(`ESU_A_STAT, 32'h0000_0100, 32'h0);
    battery_weak_error_in <= 1'b0;
    wr(`ESU_A_CTRL, 32'h1);
    wr(`ESU_A_CLR, 32'h1);
    // Port errors on both ports, then port reset bits
    for (p = 0; p < 2; p++)
    begin
      @(posedge core_clk_in);
      port_err_in <= 2'h1 << p;
      @(posedge core_clk_in);
      port_err_in <= 2'h0;
      repeat (6) @(posedge core_clk_in);
      chk(p ? serial_port_lamp_out : peripheral_port_lamp_out, 1'b0);
      wr(`ESU_A_CTRL, 32'h1 | (32'h100 << p));
      seen = 1'b0;
      repeat (12) @(posedge core_clk_in) seen |= p ? serial_port_lamp_out : peripheral_port_lamp_out;
      chk(seen, 1'b1);
    end
    // Output inhibit on and off
    wr(`ESU_A_CTRL, 32'h8001);
    repeat (2) @(posedge core_clk_in);
    chk({outputs_on_out, output_block_lamp_out}, 2'b01);
    wr(`ESU_A_CTRL, 32'h1);
    repeat (2) @(posedge core_clk_in);
    chk({outputs_on_out, output_block_lamp_out}, 2'b10);
    // Message lengths 16, 17 and random
    for (i = 0; i < 3; i++)
    begin
      n1 = (i < 2) ? 8'(16 + i) : 8'({$random(seed)} % 32);
      @(posedge core_clk_in);
      console_message_instr_in <= 1'b1;
      msg_len_in <= n1[4:0];
      repeat (2) @(posedge core_clk_in);
      chk({msg_show_out, msg_len_out}, {1'b1, (n1 > 16) ? 5'h10 : n1[4:0]});
      console_message_instr_in <= 1'b0;
    end
    // Fatal 00 ignored, then fatal over nonfatal with distinct numbers
    ev(1, 8'h00);
    rdchk(`ESU_A_STAT, 32'h0003_00FF, st(8'h00, 1'b0, 1'b0));
    n1 = bcd(1 + {$random(seed)} % 49);
    n2 = bcd(50 + {$random(seed)} % 50);
    ev(0, n1);
    repeat (25) @(posedge core_clk_in);
    ev(1, n2);
    chk({exec_run_out, outputs_on_out, error_lamp_out}, 3'b001);
    chk({power_lamp_out, run_lamp_out, log_code_out}, {2'b10, n2});
    repeat (10) @(posedge core_clk_in);
    rdchk(`ESU_A_STAT, 32'h0003_00FF, st(n2, 1'b1, 1'b1));
    wr(`ESU_A_CLR, 32'h1);
    rdchk(`ESU_A_STAT, 32'h0003_00FF, st(n2, 1'b1, 1'b1));
    program_mode_in <= 1'b1;
    ev(0, 8'h00);
    wr(`ESU_A_CLR, 32'h1);
    rdchk(`ESU_A_STAT, 32'h0003_00FF, st(8'h00, 1'b0, 1'b0));
    program_mode_in <= 1'b0;
    repeat (3) @(posedge core_clk_in);
    chk(exec_run_out, 1'b1);
    ce_in <= 1'b0;
    ev(1, n2);
    chk(exec_run_out, 1'b1);
    ce_in <= 1'b1;
    give_verdict;
  end
endmodule
`default_nettype wire
